// file: verilog/pcl_timing.sv
// Carrier, collision, latency and link integrity timing of the PHY.
//
// Functional notes
// - Link lost after link-loss interval without pulses.
// - Pulses sooner than minimum timer are rejected.
// - Maximum receive timer expiry counts missing pulse.
// - Idle transmitter sends link pulses every period.
// - One bit time is ten nanoseconds.
// - Receive data valid follows carrier sense.
// - Carrier sense rises after start-of-stream symbol.
// - Carrier sense falls after end-of-stream symbol.
// - Collision rises after start symbol while transmitting.
// - Collision falls after end-of-stream symbol.
// - Carrier sense rises after transmit enable sampled.
// - Carrier sense falls after transmit enable drops.
// - Line output starts shortly after transmit enable.
//
// Latencies count system cycles.
// Receive events run down shift
// lines and act at fixed taps.
//
// Transmit words cross clocks in
// a buffer; transmit timing runs
// from the cycle a word leaves it.
// Add two or three cycles of
// crossing time to those figures.
//
// Line pulses are synchronised,
// spaced and counted; two good
// ones bring the link up.
// Link pulses start only while
// the transmitter is idle.
//
// Collision needs a J while
// transmit carrier is up.
//
// Outputs all come from flops.
// Both clocks share one reset.
`timescale 1ns/1ps
`default_nettype none
module pcl_timing
  import pcl_pkg::*;
#(
  parameter int unsigned LOSS_CYC = LINK_LOSS_MS * CYC_PER_MS,
  parameter int unsigned MIN_RX_CYC = LINK_MIN_RX_MS * CYC_PER_MS,
  parameter int unsigned MAX_RX_CYC = LINK_MAX_RX_MS * CYC_PER_MS,
  parameter int unsigned LTX_CYC = LINK_TX_MS * CYC_PER_MS,
  parameter int FIFO_DEPTH = TX_FIFO_DEPTH
) (
  input wire logic sys_clk_in, // System clock, 40 MHz.
  input wire logic rst_n_in, // Asynchronous reset, active low.
  input wire logic link_clk_in, // MAC transmit clock.
  input wire logic mac_tx_en_in, // MAC transmit enable.
  input wire logic [3:0] mac_txd_in, // MAC transmit nibble.
  output logic mac_tx_ready_out, // Transmit buffer has room.
  input wire logic line_ready_in, // Line encoder takes a nibble.
  input wire logic rx_j_start_in, // Pulse at start of J symbol.
  input wire logic rx_t_start_in, // Pulse at start of T symbol.
  input wire logic [3:0] rx_nibble_in, // Decoded receive nibble.
  input wire logic twisted_pair_in_pulse_in, // Link pulse level.
  output logic crs_out, // Carrier sense.
  output logic col_out, // Collision.
  output logic rx_dv_out, // Receive data valid.
  output logic [3:0] rxd_out, // Receive nibble to the MAC.
  output logic tx_twisted_pair_en_out, // Line output active.
  output logic [3:0] tx_twisted_pair_out, // Line output nibble.
  output logic link_pulse_out, // Link pulse to the line.
  output logic link_up_out // Link integrity passed.
);
  // Taps cover the longest latency;
  // timers hold the link counts.
  localparam int SH = 16; // Length of the event delay lines.
  localparam int CW = 24; // Width of the millisecond counters.

  // Bad overrides stop elaboration.
  // Counts and delays must fit the counters and delay lines.
  generate
    if (LOSS_CYC >= (1 << CW) || MAX_RX_CYC >= (1 << CW) ||
        LTX_CYC >= (1 << CW) || MIN_RX_CYC >= (1 << CW) ||
        MIN_RX_CYC < 1 || LTX_CYC < 2)
    begin : g_bad_cnt
      $error("Link timer counts must fit in the timer width.");
    end
    if (CRS_TX_OFF_CYC > SH || COL_OFF_CYC > SH ||
        RXD_DLY_CYC > SH || RX_DV_CYC < 2 || TX_LINE_CYC > SH)
    begin : g_bad_dly
      $error("Latency counts must fit the delay lines.");
    end
  endgenerate

  // Link-side state: the enable of the last word written.
  typedef struct packed {
    logic en_prev;
  } pcl_lnk_t;

  // Bit k of a delay line is k edges old.
  // System-side state, registered as one word.
  typedef struct packed {
    logic [SH-1:0] j_sh;
    logic [SH-1:0] t_sh;
    logic [SH-1:0] rise_sh;
    logic [SH-1:0] fall_sh;
    logic [SH-1:0] crs_hist;
    logic [SH-1:0][3:0] rxd_pipe;
    logic [SH-1:0][4:0] line_pipe;
    logic crs_rx;
    logic crs_tx;
    logic crs;
    logic col;
    logic rx_dv;
    logic [3:0] rxd;
    logic tx_en;
    logic [3:0] tx_nib;
    logic line_en;
    logic [3:0] line_nib;
    logic lp_prev;
    logic [CW-1:0] since;
    logic [1:0] good;
    pcl_link_t link;
    logic [CW-1:0] tx_cnt;
    logic [3:0] pw_cnt;
    logic lp_out;
  } pcl_st_t;

  pcl_lnk_t l_r;
  pcl_lnk_t l_nxt;
  pcl_st_t s_r;
  pcl_st_t s_nxt;
  logic lp_sync; // Link pulse level after two flops.
  logic lp_edge; // Rising edge of the link pulse.
  logic pop; // A buffered word is taken this cycle.
  logic tx_idle; // Nothing to send on the line.

  pcl_fifo_if #(.W(TX_WORD_W)) fif ();

  // A full buffer drops ready to the MAC.
  // Nothing is lost while ready is honoured.
  // Transmit words cross from the MAC clock to the system clock.
  pcl_fifo #(
    .W(TX_WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .wr_clk_in(link_clk_in),
    .rd_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .bus(fif.fifo)
  );

  // Its edge shows two to three cycles late.
  // The line pulse is asynchronous to the system clock.
  pcl_sync #(.W(1)) u_lp_sync (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .d_in(twisted_pair_in_pulse_in),
    .q_out(lp_sync)
  );

  // Words are written while enabled and once more to record the drop.
  // The last written enable is kept, so a
  // refused closing word is offered again.
  always_comb
  begin
    fif.wr_valid = mac_tx_en_in | l_r.en_prev;
    fif.wr_data = {mac_tx_en_in, mac_txd_in};
    l_nxt.en_prev = l_r.en_prev;
    if (fif.wr_valid && fif.wr_ready)
    begin
      l_nxt.en_prev = mac_tx_en_in;
    end
  end

  // It clears with the shared reset.
  // Link-side register.
  always_ff @(posedge link_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      l_r <= '0;
    end
    else
    begin
      l_r <= l_nxt;
    end
  end

  // Edge and idle decodes for the comb.
  // The line encoder paces the buffer, so it can fill and stall the MAC.
  assign fif.rd_ready = line_ready_in;
  assign pop = fif.rd_valid & line_ready_in;
  assign lp_edge = lp_sync & ~s_r.lp_prev;
  assign tx_idle = ~s_r.tx_en & ~s_r.crs_tx;

  // Next state of the system side.
  always_comb
  begin
    // Keep every field unless set below.
    s_nxt = s_r;
    // Delay lines advance each cycle; one bit time is 10 ns.
    s_nxt.j_sh = {s_r.j_sh[SH-2:0], rx_j_start_in};
    s_nxt.t_sh = {s_r.t_sh[SH-2:0], rx_t_start_in};
    s_nxt.rxd_pipe = {s_r.rxd_pipe[SH-2:0], rx_nibble_in};
    s_nxt.crs_hist = {s_r.crs_hist[SH-2:0], s_r.crs_rx};

    // A taken word updates the transmit enable and nibble.
    s_nxt.rise_sh = {s_r.rise_sh[SH-2:0], 1'b0};
    s_nxt.fall_sh = {s_r.fall_sh[SH-2:0], 1'b0};
    if (pop)
    begin
      s_nxt.tx_en = fif.rd_data[TX_WORD_EN_BIT];
      s_nxt.tx_nib = fif.rd_data[3:0];
      s_nxt.rise_sh[0] = fif.rd_data[TX_WORD_EN_BIT] & ~s_r.tx_en;
      s_nxt.fall_sh[0] = ~fif.rd_data[TX_WORD_EN_BIT] & s_r.tx_en;
    end
    // Taking the next-state word makes the
    // line lag a pop by exactly its latency.
    s_nxt.line_pipe = {s_r.line_pipe[SH-2:0], {s_nxt.tx_en, s_nxt.tx_nib}};

    // T goes first: no late J reopens.
    // Receive carrier rises after J and falls after T.
    if (s_r.t_sh[CRS_RX_OFF_CYC-1])
    begin
      s_nxt.crs_rx = 1'b0;
    end
    else if (s_r.j_sh[CRS_RX_ON_CYC-1])
    begin
      s_nxt.crs_rx = 1'b1;
    end

    // Transmit carrier follows the sampled enable; a rise wins.
    if (s_r.rise_sh[CRS_TX_ON_CYC-1])
    begin
      s_nxt.crs_tx = 1'b1;
    end
    else if (s_r.fall_sh[CRS_TX_OFF_CYC-1])
    begin
      s_nxt.crs_tx = 1'b0;
    end
    s_nxt.crs = s_nxt.crs_rx | s_nxt.crs_tx;

    // No transmit carrier, no new collision.
    // Collision needs a receive while transmitting; T ends it.
    if (s_r.t_sh[COL_OFF_CYC-1])
    begin
      s_nxt.col = 1'b0;
    end
    else if (s_r.j_sh[COL_ON_CYC-1] && s_r.crs_tx)
    begin
      s_nxt.col = 1'b1;
    end

    // Data taps add both delays.
    // Data valid trails receive carrier and drops with it.
    s_nxt.rx_dv = s_nxt.crs_rx & s_r.crs_hist[RX_DV_CYC-2];
    s_nxt.rxd = s_nxt.rx_dv ? s_r.rxd_pipe[RXD_DLY_CYC-1] : 4'h0;

    // Line output is the transmit word a fixed time later.
    {s_nxt.line_en, s_nxt.line_nib} = s_r.line_pipe[TX_LINE_CYC-1];

    // Saturating keeps quiet lines old.
    // Time since the last accepted link pulse saturates.
    s_nxt.lp_prev = lp_sync;
    if (s_r.since != {CW{1'b1}})
    begin
      s_nxt.since = s_r.since + 1'b1;
    end
    if (lp_edge && s_r.since >= CW'(MIN_RX_CYC))
    begin
      // Accepted pulse restarts the timer and counts toward link up.
      s_nxt.since = '0;
      if (s_r.good != 2'h3)
      begin
        s_nxt.good = s_r.good + 1'b1;
      end
      if (s_nxt.good >= 2'(LINK_PULSES_UP))
      begin
        s_nxt.link = PCL_LINK_UP;
      end
    end
    else if (s_r.since >= CW'(MAX_RX_CYC))
    begin
      // Missing pulse resets the run of good pulses.
      s_nxt.good = '0;
    end
    if (s_r.since >= CW'(LOSS_CYC))
    begin
      s_nxt.link = PCL_LINK_DOWN;
    end

    // Activity restarts the period;
    // a pulse under way runs out.
    // Idle transmitter emits a link pulse each period.
    if (!tx_idle)
    begin
      s_nxt.tx_cnt = '0;
    end
    else if (s_r.tx_cnt >= CW'(LTX_CYC - 1))
    begin
      s_nxt.tx_cnt = '0;
      s_nxt.pw_cnt = 4'(LINK_PW_CYC);
    end
    else
    begin
      s_nxt.tx_cnt = s_r.tx_cnt + 1'b1;
    end
    if (s_r.pw_cnt != 4'h0 && !(tx_idle &&
        s_r.tx_cnt >= CW'(LTX_CYC - 1)))
    begin
      s_nxt.pw_cnt = s_r.pw_cnt - 1'b1;
    end
    s_nxt.lp_out = (s_nxt.pw_cnt != 4'h0);
  end

  // Hold reset two edges of each clock.
  // System-side register; the link starts down and all outputs low.
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s_r <= '0;
      s_r.link <= PCL_LINK_DOWN;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // One-hot state: its up bit drives the pin.
  // Ready comes from the buffer's flop.
  // All outputs come straight from registers.
  assign mac_tx_ready_out = fif.wr_ready;
  assign crs_out = s_r.crs;
  assign col_out = s_r.col;
  assign rx_dv_out = s_r.rx_dv;
  assign rxd_out = s_r.rxd;
  assign tx_twisted_pair_en_out = s_r.line_en;
  assign tx_twisted_pair_out = s_r.line_nib;
  assign link_pulse_out = s_r.lp_out;
  assign link_up_out = s_r.link[1];
endmodule
`default_nettype wire

// file: verilog/pcl_pkg.sv
// Shared constants for the carrier, collision and link timing block.
package pcl_pkg;

  // Clock and bit time in picoseconds.
  localparam int SYS_CLK_PS = 25000;
  localparam int BIT_TIME_PS = 10000;
  localparam int CYC_PER_MS = 1_000_000_000 / SYS_CLK_PS;

  // Least time in tenths of a bit time, rounded up to cycles, at least one.
  function automatic int cyc_min(input int bt10);
    int c;
    c = (bt10 * BIT_TIME_PS + 10 * SYS_CLK_PS - 1) / (10 * SYS_CLK_PS);
    return (c < 1) ? 1 : c;
  endfunction

  // Longest time in tenths of a bit time, rounded down, at least one.
  function automatic int cyc_max(input int bt10);
    int c;
    c = (bt10 * BIT_TIME_PS) / (10 * SYS_CLK_PS);
    return (c < 1) ? 1 : c;
  endfunction

  // Latency figures in tenths of a bit time.
  localparam int RX_DV_BT10 = 30;
  localparam int CRS_RX_ON_BT10 = 120;
  localparam int CRS_RX_OFF_BT10 = 100;
  localparam int COL_ON_BT10 = 160;
  localparam int COL_OFF_BT10 = 170;
  localparam int CRS_TX_ON_BT10 = 200;
  localparam int CRS_TX_OFF_BT10 = 240;
  localparam int TX_LINE_MAX_BT10 = 57;

  // Latencies in system clock cycles.
  localparam int RX_DV_CYC = cyc_min(RX_DV_BT10);
  localparam int CRS_RX_ON_CYC = cyc_min(CRS_RX_ON_BT10);
  localparam int CRS_RX_OFF_CYC = cyc_min(CRS_RX_OFF_BT10);
  localparam int COL_ON_CYC = cyc_min(COL_ON_BT10);
  localparam int COL_OFF_CYC = cyc_min(COL_OFF_BT10);
  localparam int CRS_TX_ON_CYC = cyc_min(CRS_TX_ON_BT10);
  localparam int CRS_TX_OFF_CYC = cyc_min(CRS_TX_OFF_BT10);
  localparam int TX_LINE_CYC = cyc_max(TX_LINE_MAX_BT10);
  localparam int RXD_DLY_CYC = CRS_RX_ON_CYC + RX_DV_CYC;

  // Link integrity times in milliseconds and nanoseconds.
  localparam int LINK_LOSS_MS = 50;
  localparam int LINK_MIN_RX_MS = 2;
  localparam int LINK_MAX_RX_MS = 50;
  localparam int LINK_TX_MS = 8;
  localparam int LINK_PW_NS = 60;
  localparam int LINK_PW_CYC = (LINK_PW_NS * 1000 + SYS_CLK_PS - 1)
                               / SYS_CLK_PS;
  localparam int LINK_PULSES_UP = 2;

  // Transmit buffer shape and word layout.
  localparam int TX_FIFO_DEPTH = 16;
  localparam int TX_WORD_W = 5;
  localparam int TX_WORD_EN_BIT = 4;

  // Link integrity states, one-hot.
  typedef enum logic [1:0] {
    PCL_LINK_DOWN = 2'h1,
    PCL_LINK_UP = 2'h2
  } pcl_link_t;

endpackage

// file: verilog/pcl_fifo_if.sv
// Interface that joins the timing block to its transmit buffer.
`timescale 1ns/1ps
`default_nettype none
interface pcl_fifo_if #(parameter int W = 5);
  logic wr_valid; // Write word offered.
  logic [W-1:0] wr_data; // Word to write.
  logic wr_ready; // Buffer has room.
  logic rd_valid; // Word available.
  logic [W-1:0] rd_data; // Word at the head.
  logic rd_ready; // Consumer takes the head.
  modport fifo (input wr_valid, wr_data, rd_ready,
                output wr_ready, rd_valid, rd_data);
  modport user (output wr_valid, wr_data, rd_ready,
                input wr_ready, rd_valid, rd_data);
endinterface
`default_nettype wire

// file: verilog/pcl_sync.sv
// Two flip-flop synchroniser for levels entering the clock's domain.
`timescale 1ns/1ps
`default_nettype none
module pcl_sync #(parameter int W = 1) (
  input wire logic clk_in, // Destination clock.
  input wire logic rst_n_in, // Asynchronous reset, active low.
  input wire logic [W-1:0] d_in, // Level from another domain.
  output logic [W-1:0] q_out // Synchronised level.
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pcl_sync_st_t;
  pcl_sync_st_t st_r;
  pcl_sync_st_t st_nxt;

  // The first stage feeds only the second stage.
  always_comb
  begin
    st_nxt.s1 = d_in;
    st_nxt.s2 = st_r.s1;
  end

  // Both stages clear at reset.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign q_out = st_r.s2;
endmodule
`default_nettype wire

// file: verilog/pcl_fifo.sv
// Dual-clock FIFO with gray-coded pointers and registered write ready.
`timescale 1ns/1ps
`default_nettype none
module pcl_fifo #(
  parameter int W = 5,
  parameter int DEPTH = 16
) (
  input wire logic wr_clk_in, // Write side clock.
  input wire logic rd_clk_in, // Read side clock.
  input wire logic rst_n_in, // Asynchronous reset, active low.
  pcl_fifo_if.fifo bus // Write and read handshakes.
);
  localparam int AW = $clog2(DEPTH);

  // Depth must be a power of two of at least four.
  generate
    if (DEPTH < 4 || (1 << AW) != DEPTH)
    begin : g_bad_depth
      $error("FIFO depth must be a power of two of at least four.");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic ready;
  } pcl_fifo_wr_t;
  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
  } pcl_fifo_rd_t;

  pcl_fifo_wr_t w_r;
  pcl_fifo_wr_t w_nxt;
  pcl_fifo_rd_t r_r;
  pcl_fifo_rd_t r_nxt;
  logic [AW:0] rgray_w; // Read pointer seen on the write side.
  logic [AW:0] wgray_r; // Write pointer seen on the read side.

  pcl_sync #(.W(AW + 1)) u_rsync (
    .clk_in(wr_clk_in),
    .rst_n_in(rst_n_in),
    .d_in(r_r.gray),
    .q_out(rgray_w)
  );
  pcl_sync #(.W(AW + 1)) u_wsync (
    .clk_in(rd_clk_in),
    .rst_n_in(rst_n_in),
    .d_in(w_r.gray),
    .q_out(wgray_r)
  );

  // Write side stores a word and predicts room for the next cycle.
  always_comb
  begin
    w_nxt = w_r;
    if (bus.wr_valid && w_r.ready)
    begin
      w_nxt.mem[w_r.bin[AW-1:0]] = bus.wr_data;
      w_nxt.bin = w_r.bin + 1'b1;
    end
    w_nxt.gray = w_nxt.bin ^ (w_nxt.bin >> 1);
    w_nxt.ready = (w_nxt.gray !=
                   {~rgray_w[AW:AW-1], rgray_w[AW-2:0]});
  end

  // Read side advances when the consumer takes the head.
  always_comb
  begin
    r_nxt = r_r;
    if (bus.rd_ready && bus.rd_valid)
    begin
      r_nxt.bin = r_r.bin + 1'b1;
    end
    r_nxt.gray = r_nxt.bin ^ (r_nxt.bin >> 1);
  end

  // Write domain registers; the buffer starts empty, ready low until the first write edge.
  always_ff @(posedge wr_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      w_r <= '0;
    end
    else
    begin
      w_r <= w_nxt;
    end
  end

  // Read domain registers.
  always_ff @(posedge rd_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      r_r <= '0;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  assign bus.wr_ready = w_r.ready;
  assign bus.rd_valid = (r_r.gray != wgray_r);
  assign bus.rd_data = w_r.mem[r_r.bin[AW-1:0]];
endmodule
`default_nettype wire

// file: dv/pcl_timing_monitor.sv
// Checker of receive, collision and link timing at the block's ports.
`timescale 1ns/1ps
`default_nettype none
module pcl_timing_monitor #(
  parameter int unsigned LOSS_CYC = 400, // Link-loss time in cycles.
  parameter int unsigned LTX_CYC = 100 // Link pulse period in cycles.
) (
  input wire logic sys_clk_in, // System clock.
  input wire logic rst_n_in, // Reset, active low.
  input wire logic rx_j_start_in, // Start symbol pulse.
  input wire logic rx_t_start_in, // End symbol pulse.
  input wire logic [3:0] rx_nibble_in, // Receive nibble.
  input wire logic twisted_pair_in_pulse_in, // Line pulse level.
  input wire logic crs_out, // Carrier sense.
  input wire logic col_out, // Collision.
  input wire logic rx_dv_out, // Receive data valid.
  input wire logic [3:0] rxd_out, // Receive nibble out.
  input wire logic link_pulse_out, // Sent link pulse.
  input wire logic link_up_out // Link integrity passed.
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [31:0] gap_r; // Low cycles since the last sent pulse.
  logic [31:0] quiet_r; // Cycles since the line input was last high.
  // Counts pulse spacing and line quiet time for the link checks.
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      gap_r <= 32'h0;
      quiet_r <= 32'h0;
    end
    else
    begin
      gap_r <= link_pulse_out ? 32'h0 : gap_r + 32'h1;
      quiet_r <= twisted_pair_in_pulse_in ? 32'h0 : quiet_r + 32'h1;
    end
  crs_rise_a: assert property (
    rx_j_start_in |-> ##6 crs_out)
    else $error("Carrier sense missing after start symbol.");
  dv_rise_a: assert property (
    rx_j_start_in |-> ##7 !rx_dv_out ##1 rx_dv_out)
    else $error("Data valid off its slot after carrier.");
  dv_crs_a: assert property (
    rx_dv_out |-> crs_out)
    else $error("Data valid without carrier sense.");
  rxd_pipe_a: assert property (
    rx_dv_out |-> rxd_out == $past(rx_nibble_in, 8))
    else $error("Receive nibble not the delayed input.");
  rxd_idle_a: assert property (
    !rx_dv_out |-> rxd_out == 4'h0)
    else $error("Receive nibble not zero while invalid.");
  dv_fall_a: assert property (
    rx_t_start_in |-> ##5 !rx_dv_out)
    else $error("Data valid held after end symbol.");
  col_fall_a: assert property (
    rx_t_start_in |-> ##8 !col_out)
    else $error("Collision held after end symbol.");
  pulse_width_a: assert property (
    $rose(link_pulse_out) |-> link_pulse_out[*3] ##1 !link_pulse_out)
    else $error("Link pulse width wrong.");
  pulse_gap_a: assert property (
    $rose(link_pulse_out) |-> gap_r >= LTX_CYC - 5)
    else $error("Link pulses too close.");
  link_loss_a: assert property (
    quiet_r > LOSS_CYC + 8 |-> !link_up_out)
    else $error("Link kept up on a quiet line.");
endmodule
bind pcl_timing pcl_timing_monitor #(.LOSS_CYC(LOSS_CYC), .LTX_CYC(LTX_CYC))
  pcl_timing_monitor_inst (.sys_clk_in, .rst_n_in, .rx_j_start_in,
  .rx_t_start_in, .rx_nibble_in, .twisted_pair_in_pulse_in, .crs_out,
  .col_out, .rx_dv_out, .rxd_out, .link_pulse_out, .link_up_out);
`default_nettype wire

// file: dv/pcl_mac_model.sv
// Behavioural transmitting MAC that respects the buffer's ready.
`timescale 1ns/1ps
`default_nettype none
module pcl_mac_model (
  input wire logic link_clk_in, // MAC transmit clock.
  input wire logic ready_in, // Buffer has room.
  output logic tx_en_out, // Transmit enable.
  output logic [3:0] txd_out, // Transmit nibble.
  output int taken_out // Words taken in this frame.
);
  logic ready_s; // Ready as the coming edge will see it.
  logic busy = 1'b0; // A frame is in progress.
  initial
  begin
    tx_en_out = 1'b0;
    txd_out = 4'h0;
    taken_out = 0;
  end
  // Samples ready mid-cycle, since it only changes on the rising edge.
  always @(negedge link_clk_in)
    ready_s = ready_in;
  // Idle data toggles so nothing can lean on a stale nibble.
  always @(posedge link_clk_in)
    if (!busy)
      txd_out <= ~txd_out;
  // Sends n words, each held until an edge at which ready was high.
  task automatic send(input int n);
    busy = 1'b1;
    taken_out = 0;
    @(posedge link_clk_in);
    tx_en_out <= 1'b1;
    txd_out <= 4'h1;
    while (taken_out < n)
    begin
      @(posedge link_clk_in);
      if (ready_s)
      begin
        taken_out++;
        txd_out <= 4'(taken_out + 1);
      end
    end
    tx_en_out <= 1'b0;
    // Let an edge pass before idle toggling resumes.
    @(posedge link_clk_in);
    busy = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: dv/test_pcl_timing.sv
// Self-checking bench for the carrier, collision and link timing block.
`timescale 1ns/1ps
`default_nettype none
module test_pcl_timing;
  import pcl_pkg::*;
  localparam int LOSS_P = 400; // Shortened link-loss time.
  localparam int LTX_P = 100; // Shortened link pulse period.
  logic sys_clk_in = 1'b0; // System clock, 25 ns.
  logic link_clk_in = 1'b0; // Link clock, 30 ns.
  logic rst_n_in = 1'b0; // Reset, active low.
  logic line_ready_in = 1'b1; // Line takes words.
  logic rx_j_start_in = 1'b0; // Start symbol pulse.
  logic rx_t_start_in = 1'b0; // End symbol pulse.
  logic [3:0] rx_nibble_in = 4'h0; // Counting receive nibble.
  logic twisted_pair_in_pulse_in = 1'b0; // Line pulse level.
  logic mac_tx_en_in, mac_tx_ready_out, tx_twisted_pair_en_out;
  logic [3:0] mac_txd_in, rxd_out, tx_twisted_pair_out;
  logic crs_out, col_out, rx_dv_out, link_pulse_out, link_up_out;
  int err_total = 0; // Mismatches.
  int n_tests = 0; // Comparisons.
  int taken; // Words the MAC has handed over.
  int n, m; // Cycle counts.
  logic [3:0] jn; // Nibble taken with the start symbol.
  always #12.5 sys_clk_in = ~sys_clk_in;
  always #15 link_clk_in = ~link_clk_in;
  // A new receive nibble every cycle makes the data path visible.
  always @(posedge sys_clk_in)
    rx_nibble_in <= rx_nibble_in + 4'h1;
  pcl_timing #(.LOSS_CYC(LOSS_P), .MIN_RX_CYC(20), .MAX_RX_CYC(400),
    .LTX_CYC(LTX_P)) pcl_timing_inst (.sys_clk_in, .rst_n_in, .link_clk_in,
    .mac_tx_en_in, .mac_txd_in, .mac_tx_ready_out, .line_ready_in,
    .rx_j_start_in, .rx_t_start_in, .rx_nibble_in, .twisted_pair_in_pulse_in,
    .crs_out, .col_out, .rx_dv_out, .rxd_out, .tx_twisted_pair_en_out,
    .tx_twisted_pair_out, .link_pulse_out, .link_up_out);
  pcl_mac_model pcl_mac_model_inst (.link_clk_in,
    .ready_in(mac_tx_ready_out), .tx_en_out(mac_tx_en_in),
    .txd_out(mac_txd_in), .taken_out(taken));
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d.", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Compares one value and reports a mismatch.
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // Lets k edges pass, then waits for their updates to land.
  task automatic settle(input int k);
    repeat (k) @(posedge sys_clk_in);
    #1;
  endtask
  // Picks the output that a bounded wait watches.
  function automatic logic sel(input int w);
    case (w)
      0: return crs_out;
      1: return tx_twisted_pair_en_out;
      2: return link_up_out;
      3: return mac_tx_ready_out;
      default: return link_pulse_out;
    endcase
  endfunction
  // Counts cycles until an output reaches a level; a hang ends the run.
  task automatic wait_lvl(input int w, input logic lvl, output int c);
    c = 0;
    while (sel(w) !== lvl)
    begin
      settle(1);
      c++;
      if (c > 3000)
      begin
        err_total++;
        $display("wrong value wait %0d expected %0h seen none", w, lvl);
        report_and_stop();
      end
    end
  endtask
  // Sends a one-cycle start or end symbol; returns at its sampling edge.
  task automatic sym(input bit t);
    @(posedge sys_clk_in);
    rx_t_start_in <= t;
    rx_j_start_in <= !t;
    #1 jn = rx_nibble_in;
    @(posedge sys_clk_in);
    rx_t_start_in <= 1'b0;
    rx_j_start_in <= 1'b0;
  endtask
  // Drives one line pulse three cycles wide.
  task automatic lp();
    @(posedge sys_clk_in);
    twisted_pair_in_pulse_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    twisted_pair_in_pulse_in <= 1'b0;
  endtask
  // Receive frame: carrier, data valid and data at their exact cycles.
  task automatic t_rx();
    sym(0);
    settle(4);
    chk("crs early", 0, crs_out);
    settle(1);
    chk("crs on", 1, crs_out);
    settle(1);
    chk("dv early", 0, rx_dv_out);
    settle(1);
    chk("dv on", 1, rx_dv_out);
    chk("rxd", jn, rxd_out);
    sym(1);
    settle(3);
    chk("crs held", 1, crs_out);
    settle(1);
    chk("crs off", 0, {crs_out, rx_dv_out});
    $display("Receive test done.");
  endtask
  // Transmit frame: line start, then carrier rise and fall offsets.
  task automatic t_tx();
    fork
      pcl_mac_model_inst.send(6);
    join_none
    wait_lvl(1, 1'b1, n);
    chk("line nibble", 4'h1, tx_twisted_pair_out);
    wait_lvl(0, 1'b1, n);
    chk("crs tx on", 6, n);
    wait_lvl(1, 1'b0, n);
    wait_lvl(0, 1'b0, n);
    chk("crs tx off", 8, n);
    $display("Transmit test done.");
  endtask
  // A start symbol during transmission raises and drops collision.
  task automatic t_col();
    fork
      pcl_mac_model_inst.send(30);
    join_none
    wait_lvl(0, 1'b1, n);
    sym(0);
    settle(6);
    chk("col early", 0, col_out);
    settle(1);
    chk("col on", 1, col_out);
    sym(1);
    settle(6);
    chk("col held", 1, col_out);
    settle(1);
    chk("col off", 0, col_out);
    wait_lvl(0, 1'b0, n);
    $display("Collision test done.");
  endtask
  // Fills the buffer with the line stalled, then drains it.
  task automatic t_fill();
    @(posedge sys_clk_in);
    line_ready_in <= 1'b0;
    fork
      pcl_mac_model_inst.send(24);
    join_none
    wait_lvl(3, 1'b0, n);
    settle(20);
    chk("words held", TX_FIFO_DEPTH, taken);
    chk("stalled line", 0, crs_out);
    @(posedge sys_clk_in);
    line_ready_in <= 1'b1;
    wait_lvl(0, 1'b1, n);
    wait_lvl(0, 1'b0, n);
    chk("words sent", 24, taken);
    chk("ready back", 1, mac_tx_ready_out);
    $display("Buffer test done.");
  endtask
  // Pulse spacing, early pulse, link up, link loss and missing pulse.
  task automatic t_link();
    wait_lvl(4, 1'b0, n);
    wait_lvl(4, 1'b1, n);
    wait_lvl(4, 1'b0, n);
    wait_lvl(4, 1'b1, m);
    chk("pulse gap", 1, n + m >= LTX_P && n + m <= 3 * LTX_P);
    lp();
    settle(8);
    lp();
    settle(8);
    chk("early pulse", 0, link_up_out);
    lp();
    settle(6);
    chk("link up", 1, link_up_out);
    wait_lvl(2, 1'b0, n);
    chk("loss time", 1, n >= LOSS_P - 20 && n <= LOSS_P + 10);
    lp();
    settle(8);
    chk("one pulse", 0, link_up_out);
    $display("Link test done.");
  endtask
  initial
  begin
    repeat (16) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    settle(2);
    chk("reset outs", 0, {crs_out, col_out, rx_dv_out, link_up_out});
    chk("ready", 1, mac_tx_ready_out);
    t_rx();
    t_tx();
    t_col();
    t_fill();
    t_link();
    report_and_stop();
  end
endmodule
`default_nettype wire
